//--- design/counter_pkg.sv
`default_nettype none
package counter_pkg;
  // counter and time widths, values in decimal units
  localparam int          CNT_W        = 14;
  localparam int          TIME_W       = 14;
  localparam int          DP_W         = 4;
  localparam int          MODE_W       = 4;
  localparam logic [13:0] CNT_MAX      = 14'h270f;
  localparam logic [13:0] TIME_MIN     = 14'h0001;
  localparam logic [13:0] TIME_MAX     = 14'h270f;
  localparam logic [13:0] TIME_DEFAULT = 14'h000a;
  localparam logic [13:0] PRESET_RESET = 14'h0064;
  localparam logic [3:0]  DP_RESET     = 4'h0;

  // register offsets (byte addresses)
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_PRESET1  = 8'h00;
  localparam logic [7:0]  OFF_PRESET2  = 8'h04;
  localparam logic [7:0]  OFF_TIME1    = 8'h08;
  localparam logic [7:0]  OFF_TIME2    = 8'h0c;
  localparam logic [7:0]  OFF_DPOINT   = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_COMMAND  = 8'h18;

  // status and command fields
  localparam int ST_COUNT_LSB  = 0;
  localparam int ST_OUT_LSB    = 16;
  localparam int ST_TEST_BIT   = 18;
  localparam int ST_MODE_LSB   = 20;
  localparam int CMD_TEST_BIT  = 0;
  localparam int CMD_OTEST_BIT = 1;

  // mode switch bits: switch down reads as one
  localparam int MODE_TIMED_BIT  = 0;
  localparam int MODE_AFTER_BIT  = 1;
  localparam int MODE_AUTO_BIT   = 2;
  localparam int MODE_PRESET_BIT = 3;

  // timing, each time in its own unit
  localparam longint CLK_HZ        = 125_000_000;
  localparam longint TICK_MS       = 10;
  localparam longint HF_MIN_US     = 50;
  localparam longint DEB_MIN_MS    = 5;
  localparam longint TEST_MS       = 1;
  localparam longint TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam longint HF_CYCLES     = CLK_HZ / 1_000_000 * HF_MIN_US;
  localparam longint DEB_CYCLES    = CLK_HZ / 1000 * DEB_MIN_MS;
  localparam longint TEST_CYCLES   = CLK_HZ / 1000 * TEST_MS;

  typedef struct packed {
    logic [CNT_W-1:0]  preset1;
    logic [CNT_W-1:0]  preset2;
    logic [TIME_W-1:0] time1;
    logic [TIME_W-1:0] time2;
    logic [DP_W-1:0]   dpoint;
  } settings_t;

  localparam settings_t SETTINGS_RESET = '{PRESET_RESET, PRESET_RESET,
                                           TIME_DEFAULT, TIME_DEFAULT,
                                           DP_RESET};

  typedef struct packed {
    logic load_from_preset_mode;
    logic auto_at;
    logic auto_after;
    logic timed;
    logic off1_final;
  } mode_t;

  typedef enum logic [1:0] {TMR_IDLE  = 2'b01, TMR_RUN  = 2'b10} tmr_state_t;
  typedef enum logic [1:0] {TEST_IDLE = 2'b01, TEST_RUN = 2'b10} test_state_t;

  // modes 4 and 6 (and their preset twins) are timed by definition
  function automatic mode_t decode_mode(input logic [MODE_W-1:0] m);
    mode_t d;
    d.load_from_preset_mode = m[MODE_PRESET_BIT];
    d.auto_at    = m[MODE_AUTO_BIT] & ~m[MODE_AFTER_BIT];
    d.auto_after = m[MODE_AUTO_BIT] & m[MODE_AFTER_BIT];
    d.timed      = m[MODE_TIMED_BIT] | m[MODE_AUTO_BIT];
    d.off1_final = m[MODE_AFTER_BIT] & ~m[MODE_AUTO_BIT];
    return d;
  endfunction
endpackage
`default_nettype wire

//--- design/timed_output.sv
`default_nettype none
module timed_output #(
  parameter int TIME_W = 14
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              tick,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic [TIME_W-1:0] duration,
  output logic                   active,
  output logic                   done
);
  counter_pkg::tmr_state_t state, next_state;
  logic [TIME_W-1:0]       left, next_left;
  logic                    next_done;

  if (TIME_W < 1) begin : g_chk
    $error("timed_output needs TIME_W of at least one");
  end

  // stop beats start so a manual reset always ends the pulse
  always_comb begin
    next_state = state;
    next_left  = left;
    next_done  = 1'b0;
    if (stop) begin
      next_state = counter_pkg::TMR_IDLE;
      next_left  = '0;
    end else if (start) begin
      next_state = counter_pkg::TMR_RUN;
      next_left  = duration;
    end else if (state == counter_pkg::TMR_RUN && tick) begin
      if (left <= TIME_W'(1)) begin
        next_state = counter_pkg::TMR_IDLE;
        next_done  = 1'b1;
        next_left  = '0;
      end else begin
        next_left = left - TIME_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= counter_pkg::TMR_IDLE;
      left  <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      left  <= next_left;
      done  <= next_done;
    end
  end

  assign active = (state == counter_pkg::TMR_RUN);

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_timer_stop: assert property (stop |=> !active && left == '0)
    else $error("timed output still running after stop");
  a_timer_load: assert property (
    start && !stop |=> active && left == $past(duration))
    else $error("timed output not loaded with duration");
  a_timer_end: assert property (
    active && tick && !start && !stop && left == TIME_W'(1)
    |=> done && !active)
    else $error("timed output did not end after its time");
endmodule
`default_nettype wire

//--- design/preset_counter_with_timed_outputs.sv
`default_nettype none
module preset_counter_with_timed_outputs #(
  parameter int NUM_PRESETS = 2,
  parameter int TICK_CYCLES = int'(counter_pkg::TICK_CYCLES),
  parameter int HF_CYCLES   = int'(counter_pkg::HF_CYCLES),
  parameter int DEB_CYCLES  = int'(counter_pkg::DEB_CYCLES),
  parameter int TEST_CYCLES = int'(counter_pkg::TEST_CYCLES)
) (
  input  wire logic                             clk,
  input  wire logic                             srst,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [counter_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             count_in_n,
  input  wire logic                             debounce_sel,
  input  wire logic                             count_direction_in,
  input  wire logic                             remote_reset_n,
  input  wire logic                             program_disable_n,
  input  wire logic                             panel_reset_btn,
  input  wire logic                             panel_reset_enable,
  input  wire logic [counter_pkg::MODE_W-1:0]   mode_switch,
  output logic      [NUM_PRESETS-1:0]           sink_out,
  output logic      [NUM_PRESETS-1:0]           relay_out,
  output logic                                  display_test
);
  localparam int CW   = counter_pkg::CNT_W;
  localparam int TW   = counter_pkg::TIME_W;
  localparam int DW   = 21;
  localparam int LAST = NUM_PRESETS - 1;

  if (NUM_PRESETS < 1 || NUM_PRESETS > 2 || TICK_CYCLES < 2 ||
      HF_CYCLES < 1 || DEB_CYCLES < 1 || TEST_CYCLES < 1 ||
      DEB_CYCLES >= (1 << DW) || TICK_CYCLES >= (1 << DW) ||
      TEST_CYCLES >= (1 << DW) || HF_CYCLES >= (1 << DW)) begin : g_chk
    $error("preset counter parameters out of range");
  end

  // one step of the count, wrapping within four decimal digits
  function automatic logic [CW-1:0] step_value(input logic [CW-1:0] v,
                                               input logic up);
    if (up) begin
      return (v >= counter_pkg::CNT_MAX) ? '0 : v + CW'(1);
    end
    return (v == '0) ? counter_pkg::CNT_MAX : v - CW'(1);
  endfunction

  // writes to these are refused while programming is disabled
  function automatic logic reg_locked(input logic [7:0] a);
    if (a == counter_pkg::OFF_PRESET1) return 1'b1;
    else if (a == counter_pkg::OFF_PRESET2) return 1'b1;
    else if (a == counter_pkg::OFF_TIME1) return 1'b1;
    else if (a == counter_pkg::OFF_TIME2) return 1'b1;
    else if (a == counter_pkg::OFF_DPOINT) return 1'b1;
    else return 1'b0;
  endfunction

  function automatic logic [TW-1:0] clamp_time(input logic [31:0] v);
    if (v[TW-1:0] < counter_pkg::TIME_MIN || v[31:TW] != '0)
      return (v[31:TW] != '0) ? counter_pkg::TIME_MAX
                               : counter_pkg::TIME_MIN;
    if (v[TW-1:0] > counter_pkg::TIME_MAX) return counter_pkg::TIME_MAX;
    return v[TW-1:0];
  endfunction

  function automatic logic [CW-1:0] clamp_count(input logic [31:0] v);
    if (v[31:CW] != '0 || v[CW-1:0] > counter_pkg::CNT_MAX)
      return counter_pkg::CNT_MAX;
    return v[CW-1:0];
  endfunction

  counter_pkg::settings_t   cfg, next_cfg;
  counter_pkg::mode_t       md;
  counter_pkg::test_state_t test_state, next_test_state;
  logic [CW-1:0]            count, next_count, stepped, reset_val, pfinal;
  logic [DW-1:0]            filt_cnt, next_filt_cnt, thr;
  logic [DW-1:0]            tick_cnt, next_tick_cnt;
  logic [DW-1:0]            test_cnt, next_test_cnt;
  logic                     filt_done, next_filt_done, step, tick;
  logic                     manual_reset, wr_take, otest, next_otest;
  logic [NUM_PRESETS-1:0]   out_state, next_out_state, hit, tmr_done;
  logic [NUM_PRESETS-1:0]   tmr_start, tmr_stop, next_pins;
  logic [CW-1:0]            target [NUM_PRESETS];
  logic [TW-1:0]            dur [NUM_PRESETS];
  logic [31:0]              next_prdata;
  logic                     next_pready, next_pslverr;

  assign md = counter_pkg::decode_mode(mode_switch);
  assign manual_reset = !remote_reset_n ||
                        (panel_reset_btn && panel_reset_enable);
  assign pfinal    = (NUM_PRESETS == 2) ? cfg.preset2 : cfg.preset1;
  assign reset_val = md.load_from_preset_mode ? pfinal : '0;
  assign stepped   = step_value(count, count_direction_in);
  assign tick      = (tick_cnt == DW'(TICK_CYCLES - 1));
  assign wr_take   = psel && penable && pready && pwrite;

  // count input qualifier: one count per low pulse of at least thr cycles
  always_comb begin
    thr = debounce_sel ? DW'(DEB_CYCLES) : DW'(HF_CYCLES);
    next_filt_cnt  = filt_cnt;
    next_filt_done = filt_done;
    step           = 1'b0;
    if (count_in_n) begin
      next_filt_cnt  = '0;
      next_filt_done = 1'b0;
    end else if (!filt_done) begin
      if (filt_cnt + DW'(1) >= thr) begin
        step           = 1'b1;
        next_filt_done = 1'b1;
      end else begin
        next_filt_cnt = filt_cnt + DW'(1);
      end
    end
    next_tick_cnt = tick ? '0 : tick_cnt + DW'(1);
  end

  // per-preset compare targets and output timers
  for (genvar k = 0; k < NUM_PRESETS; k++) begin : g_out
    always_comb begin
      if (md.load_from_preset_mode) begin
        target[k] = (k == LAST) ? '0 : cfg.preset1;
      end else begin
        target[k] = (k == 0) ? cfg.preset1 : cfg.preset2;
      end
    end
    assign dur[k] = (k == 0) ? cfg.time1 : cfg.time2;
    assign hit[k] = step && stepped == target[k] && !manual_reset;
    assign tmr_start[k] = hit[k] && md.timed;
    assign tmr_stop[k]  = manual_reset ||
                          (k == 0 && LAST == 1 && md.off1_final && hit[LAST]);

    timed_output #(.TIME_W(TW)) u_timer (
      .clk      (clk),
      .srst     (srst),
      .tick     (tick),
      .start    (tmr_start[k]),
      .stop     (tmr_stop[k]),
      .duration (dur[k]),
      .active   (),
      .done     (tmr_done[k])
    );

    // output state: reset clears, hit sets, timer end or final match clears
    always_comb begin
      next_out_state[k] = out_state[k];
      if (manual_reset) begin
        next_out_state[k] = 1'b0;
      end else if (tmr_stop[k]) begin
        next_out_state[k] = 1'b0;
      end else if (hit[k]) begin
        next_out_state[k] = 1'b1;
      end else if (md.timed && tmr_done[k]) begin
        next_out_state[k] = 1'b0;
      end
    end
  end

  // count: manual reset first, then automatic reloads, then plain steps;
  // a pulse arriving with an after-time reload is kept, not dropped
  always_comb begin
    next_count = count;
    if (manual_reset) begin
      next_count = reset_val;
    end else if (md.auto_at && hit[LAST]) begin
      next_count = reset_val;
    end else if (md.auto_after && tmr_done[LAST]) begin
      next_count = step ? step_value(reset_val, count_direction_in)
                        : reset_val;
    end else if (step) begin
      next_count = stepped;
    end
  end

  // self-test runs beside the counter and never touches it
  always_comb begin
    next_test_state = test_state;
    next_test_cnt   = test_cnt;
    next_otest      = otest;
    case (test_state)
      counter_pkg::TEST_IDLE: begin
        if (wr_take && paddr == counter_pkg::OFF_COMMAND &&
            pwdata[counter_pkg::CMD_TEST_BIT]) begin
          next_test_state = counter_pkg::TEST_RUN;
          next_test_cnt   = '0;
          next_otest      = pwdata[counter_pkg::CMD_OTEST_BIT];
        end
      end
      counter_pkg::TEST_RUN: begin
        if (test_cnt == DW'(TEST_CYCLES - 1)) begin
          next_test_state = counter_pkg::TEST_IDLE;
          next_otest      = 1'b0;
        end else begin
          next_test_cnt = test_cnt + DW'(1);
        end
      end
      default: next_test_state = counter_pkg::TEST_IDLE;
    endcase
    next_pins = next_out_state;
    if (test_state == counter_pkg::TEST_RUN && otest && program_disable_n)
      next_pins = '1;
  end

  // settings writes and bus answers; ready comes one cycle after setup
  always_comb begin
    next_cfg = cfg;
    if (wr_take && !(reg_locked(paddr) && !program_disable_n)) begin
      if (paddr == counter_pkg::OFF_PRESET1)
        next_cfg.preset1 = clamp_count(pwdata);
      else if (paddr == counter_pkg::OFF_PRESET2)
        next_cfg.preset2 = clamp_count(pwdata);
      else if (paddr == counter_pkg::OFF_TIME1)
        next_cfg.time1 = clamp_time(pwdata);
      else if (paddr == counter_pkg::OFF_TIME2)
        next_cfg.time2 = clamp_time(pwdata);
      else if (paddr == counter_pkg::OFF_DPOINT)
        next_cfg.dpoint = pwdata[counter_pkg::DP_W-1:0];
    end
    next_pready  = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (psel && !penable) begin
      if (paddr == counter_pkg::OFF_PRESET1)
        next_prdata[CW-1:0] = cfg.preset1;
      else if (paddr == counter_pkg::OFF_PRESET2)
        next_prdata[CW-1:0] = cfg.preset2;
      else if (paddr == counter_pkg::OFF_TIME1)
        next_prdata[TW-1:0] = cfg.time1;
      else if (paddr == counter_pkg::OFF_TIME2)
        next_prdata[TW-1:0] = cfg.time2;
      else if (paddr == counter_pkg::OFF_DPOINT)
        next_prdata[counter_pkg::DP_W-1:0] = cfg.dpoint;
      else if (paddr == counter_pkg::OFF_STATUS) begin
        next_prdata[counter_pkg::ST_COUNT_LSB +: CW] = count;
        next_prdata[counter_pkg::ST_OUT_LSB +: NUM_PRESETS] = out_state;
        next_prdata[counter_pkg::ST_TEST_BIT] =
          (test_state == counter_pkg::TEST_RUN);
        next_prdata[counter_pkg::ST_MODE_LSB +: counter_pkg::MODE_W] =
          mode_switch;
      end else if (paddr != counter_pkg::OFF_COMMAND)
        next_pslverr = 1'b1;
      if (pwrite && reg_locked(paddr) && !program_disable_n)
        next_pslverr = 1'b1;
      if (pwrite && paddr == counter_pkg::OFF_STATUS)
        next_pslverr = 1'b1;
    end
  end

  // settings are kept in flops standing in for the retained store
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg          <= counter_pkg::SETTINGS_RESET;
      count        <= '0;
      out_state    <= '0;
      sink_out     <= '0;
      relay_out    <= '0;
      filt_cnt     <= '0;
      filt_done    <= 1'b0;
      tick_cnt     <= '0;
      test_state   <= counter_pkg::TEST_IDLE;
      test_cnt     <= '0;
      otest        <= 1'b0;
      display_test <= 1'b0;
      prdata       <= '0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else begin
      cfg          <= next_cfg;
      count        <= next_count;
      out_state    <= next_out_state;
      sink_out     <= next_pins;
      relay_out    <= next_pins;
      filt_cnt     <= next_filt_cnt;
      filt_done    <= next_filt_done;
      tick_cnt     <= next_tick_cnt;
      test_state   <= next_test_state;
      test_cnt     <= next_test_cnt;
      otest        <= next_otest;
      display_test <= (next_test_state == counter_pkg::TEST_RUN);
      prdata       <= next_prdata;
      pready       <= next_pready;
      pslverr      <= next_pslverr;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_reset_zero: assert property (manual_reset
    && !md.load_from_preset_mode |=> count == '0 && out_state == '0)
    else $error("clear-to-zero reset left count or outputs");
  a_reset_load: assert property (manual_reset
    && md.load_from_preset_mode |=> count == $past(pfinal) && out_state == '0)
    else $error("preset reload on reset wrong");
  a_count_step: assert property (step && !manual_reset &&
    !(md.auto_at && hit[LAST]) && !(md.auto_after && tmr_done[LAST])
    |=> count == $past(step_value(count, count_direction_in)))
    else $error("count did not follow direction input");
  a_hit_output: assert property (hit[LAST] && !tmr_stop[LAST]
    |=> out_state[LAST] ##1 (sink_out[LAST] || $past(manual_reset)))
    else $error("final output not set on match");
  a_lock_hold: assert property (wr_take && !program_disable_n
    |=> $stable(cfg))
    else $error("settings changed while programming disabled");
  a_pins_pair: assert property (sink_out == relay_out)
    else $error("relay and solid-state outputs differ");
  a_deb_width: assert property (step && debounce_sel
    |-> filt_cnt == DW'(DEB_CYCLES - 1) && !count_in_n)
    else $error("debounced count accepted too early");
  a_ready_once: assert property (psel && !penable
    |=> pready ##1 !pready)
    else $error("bus ready not one cycle after setup");

  c_auto_reload: cover property (md.auto_at && hit[LAST]);
  c_timer_end:   cover property (tmr_done[0] && md.timed);
  c_test_count:  cover property (test_state == counter_pkg::TEST_RUN && step);
  c_debounced:   cover property (step && debounce_sel);
endmodule
`default_nettype wire

//--- sim/pulse_source.sv
`default_nettype none
module pulse_source (
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [15:0] width,
  output logic             count_in_n,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left;
  logic [2:0]  gap;
  // the line idles high on its pull-up between pulses
  initial begin
    count_in_n = 1'b1;
    busy = 1'b0;
    left = '0;
    gap = '0;
  end
  // one low run per request, then a high gap so pulses never merge
  always @(posedge clk) begin
    if (fire && !busy) begin
      busy <= 1'b1;
      count_in_n <= 1'b0;
      left <= width;
    end else if (busy && !count_in_n) begin
      if (left > 16'h0001) left <= left - 16'h0001;
      else begin
        count_in_n <= 1'b1;
        gap <= 3'h4;
      end
    end else if (busy) begin
      if (gap != 3'h0) gap <= gap - 3'h1;
      else busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/preset_counter_with_timed_outputs_tb.sv
`default_nettype none
module preset_counter_with_timed_outputs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, cin_n, pbusy, err, dtest;
  logic deb = 0, dir = 1, rrst_n = 1, pd_n = 1, btn = 0, btn_en = 0;
  logic [3:0]  mode = 4'h0;
  logic [1:0]  sink, relay;
  logic [15:0] width = 16'h0004;
  int num_errors = 0, n_tests = 0;
  // shortened counts keep the run to a few hundred cycles
  preset_counter_with_timed_outputs #(.NUM_PRESETS(2), .TICK_CYCLES(20),
    .HF_CYCLES(3), .DEB_CYCLES(10), .TEST_CYCLES(16))
  preset_counter_with_timed_outputs_i (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_in_n(cin_n), .debounce_sel(deb), .count_direction_in(dir),
    .remote_reset_n(rrst_n), .program_disable_n(pd_n),
    .panel_reset_btn(btn), .panel_reset_enable(btn_en),
    .mode_switch(mode), .sink_out(sink), .relay_out(relay),
    .display_test(dtest));
  pulse_source pulse_source_i (.clk(clk), .fire(fire), .width(width),
    .count_in_n(cin_n), .busy(pbusy));
  always #4 clk = ~clk;
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic pulse(int w, int n);
    repeat (n) begin
      width <= w[15:0];
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      @(posedge clk);
      while (pbusy) @(posedge clk);
    end
    cyc(3);
  endtask
  task automatic count_is(logic [31:0] e);
    apb(0, counter_pkg::OFF_STATUS, '0);
    chk("count", e, rd & 32'h3fff);
  endtask
  task automatic t_defaults;
    apb(0, counter_pkg::OFF_PRESET1, '0);
    chk("preset1", 32'h64, rd);
    apb(0, counter_pkg::OFF_TIME1, '0);
    chk("time1", 32'h0a, rd);
    apb(0, 8'h40, '0);
    chk("unmapped err", 32'h1, {31'h0, err});
    count_is(32'h0);
  endtask
  task automatic t_up_latch;
    apb(1, counter_pkg::OFF_PRESET1, 32'h2);
    apb(1, counter_pkg::OFF_PRESET2, 32'h3);
    pulse(4, 2);
    chk("sink", 32'h1, {30'h0, sink});
    chk("relay", 32'h1, {30'h0, relay});
    pulse(4, 2);
    chk("sink", 32'h3, {30'h0, sink});
    count_is(32'h4);
    rrst_n <= 0;
    cyc(1);
    rrst_n <= 1;
    cyc(3);
    chk("sink", 32'h0, {30'h0, sink});
    count_is(32'h0);
  endtask
  // short runs are refused, a debounced run needs the longer width
  task automatic t_filter;
    pulse(2, 1);
    count_is(32'h0);
    deb <= 1;
    pulse(5, 1);
    count_is(32'h0);
    pulse(12, 1);
    count_is(32'h1);
    deb <= 0;
    pd_n <= 0;
    apb(1, counter_pkg::OFF_PRESET1, 32'h7);
    chk("locked err", 32'h1, {31'h0, err});
    apb(0, counter_pkg::OFF_PRESET1, '0);
    chk("preset1", 32'h2, rd);
    pd_n <= 1;
  endtask
  task automatic t_down;
    btn <= 1;
    cyc(2);
    btn <= 0;
    count_is(32'h1);
    mode <= 4'h8;
    dir <= 0;
    btn_en <= 1;
    btn <= 1;
    cyc(1);
    btn <= 0;
    count_is(32'h3);
    pulse(4, 1);
    chk("sink", 32'h1, {30'h0, sink});
    pulse(4, 2);
    count_is(32'h0);
    chk("sink", 32'h3, {30'h0, sink});
  endtask
  task automatic t_timed;
    mode <= 4'h1;
    dir <= 1;
    rrst_n <= 0;
    cyc(1);
    rrst_n <= 1;
    apb(1, counter_pkg::OFF_TIME1, 32'h2);
    pulse(4, 2);
    cyc(4);
    chk("timed on", 32'h1, {31'h0, sink[0]});
    cyc(45);
    chk("timed off", 32'h0, {31'h0, sink[0]});
  endtask
  // mode change together with a one-cycle remote reset
  task automatic mreset(logic [3:0] m);
    mode <= m;
    rrst_n <= 0;
    cyc(1);
    rrst_n <= 1;
  endtask
  // output-off-at-final, auto reset at preset and after the timed output
  task automatic t_modes;
    apb(1, counter_pkg::OFF_TIME2, 32'h0);
    apb(0, counter_pkg::OFF_TIME2, '0);
    chk("time2 min", 32'h1, rd);
    apb(1, counter_pkg::OFF_TIME2, 32'h2);
    mreset(4'h2);
    pulse(4, 2);
    chk("sink", 32'h1, {30'h0, sink});
    pulse(4, 1);
    chk("sink", 32'h2, {30'h0, sink});
    mreset(4'h4);
    pulse(4, 3);
    chk("sink2", 32'h1, {31'h0, sink[1]});
    count_is(32'h0);
    mreset(4'h6);
    pulse(4, 3);
    count_is(32'h3);
    cyc(35);
    count_is(32'h0);
    chk("sink", 32'h0, {30'h0, sink});
  endtask
  // self-test beside counting; program disable keeps the outputs quiet
  task automatic t_selftest;
    mreset(4'h0);
    apb(1, counter_pkg::OFF_COMMAND, 32'h3);
    chk("display test", 32'h1, {31'h0, dtest});
    cyc(1);
    chk("forced sink", 32'h3, {30'h0, sink});
    pulse(4, 1);
    count_is(32'h1);
    chk("display test", 32'h0, {31'h0, dtest});
    chk("sink", 32'h0, {30'h0, sink});
    pd_n <= 0;
    apb(1, counter_pkg::OFF_COMMAND, 32'h3);
    cyc(1);
    chk("locked sink", 32'h0, {30'h0, sink});
    cyc(20);
    pd_n <= 1;
  endtask
  initial begin
    cyc(6);
    srst <= 0;
    cyc(1);
    t_defaults();
    t_up_latch();
    t_filter();
    t_down();
    t_timed();
    t_modes();
    t_selftest();
    complete_run();
  end
  // watchdog well beyond the expected length of the run
  initial begin
    cyc(5000);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
